// [nvc_pkg.sv]
// Constants, command and pin types for the host-side controller of a
// byte-wide shadowed static RAM. Assumes a 125 MHz mclk.
package nvc_pkg;

    // Clock
    localparam int CLK_NS = 8;

    // Pin timing of one access, slowest speed grade
    localparam int ACC_NS = 55;
    localparam int WP_NS = 40;
    localparam int HZ_NS = 20;
    localparam int SYNC_STAGES = 2;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HZ_CYC = (HZ_NS + CLK_NS - 1) / CLK_NS;

    // Hardware save request: hold the pin until the device has taken it over
    localparam int HSB_BL_NS = 300;
    localparam int HSB_HOLD_CYC = (HSB_BL_NS + CLK_NS - 1) / CLK_NS;
    localparam int HSB_SETTLE_CYC = SYNC_STAGES + 1;

    // Nonvolatile durations (maxima the host must wait out)
    localparam int SAVE_MS = 10;
    localparam int LOAD_US = 20;
    localparam int PWRUP_US = 550;
    localparam int DRAIN_US = 1;
    localparam int SAVE_CYC = (SAVE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_CYC = (LOAD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_CYC = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_W = 21;

    // Six-read mode sequence on the low fourteen address bits
    localparam int SEQ_LEN = 6;
    localparam logic [4:0][13:0] SEQ_PREFIX = {14'h303F, 14'h3C1F, 14'h03E0,
                                               14'h31C7, 14'h0E38};
    localparam logic [13:0] SEQ_SAVE_LAST = 14'h0FC0;
    localparam logic [13:0] SEQ_LOAD_LAST = 14'h0C63;

    // Memory geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    typedef enum logic [2:0] {
        NVC_OP_READ,
        NVC_OP_WRITE,
        NVC_OP_SW_SAVE,
        NVC_OP_SW_LOAD,
        NVC_OP_HW_SAVE
    } nvc_op_t;

    typedef struct packed {
        nvc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvc_cmd_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr_lines;
    } nvc_pins_t;

endpackage

// [nvc_cycle.sv]
// One chip-select-controlled read or write cycle on the memory pins.
// Assumes the caller pulses start only while busy is low.
`timescale 1ns/10ps
`default_nettype none

module nvc_cycle (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Request
    input wire logic start,
    input wire logic is_write,
    input wire logic [nvc_pkg::ADDR_W-1:0] addr,
    input wire logic [nvc_pkg::DATA_W-1:0] wdata,
    output logic busy,
    output logic done,
    output logic [nvc_pkg::DATA_W-1:0] rdata_q,
    // Memory pins
    output nvc_pkg::nvc_pins_t pins_q,
    output logic [nvc_pkg::DATA_W-1:0] byte_lines_o_q,
    output logic byte_lines_oe_q,
    input wire logic [nvc_pkg::DATA_W-1:0] byte_lines_i
);

    typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOV} nvc_phase_t;

    nvc_phase_t phase_q;
    logic [3:0] cnt_q;
    logic wr_q;
    logic [nvc_pkg::DATA_W-1:0] dq_meta_q;
    logic [nvc_pkg::DATA_W-1:0] dq_sync_q;

    wire cnt_zero = (cnt_q == 4'h0);
    assign busy = (phase_q != PH_IDLE);
    assign done = (phase_q == PH_RECOV) && cnt_zero;

    // Two stages before the read data is looked at
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dq_meta_q <= 8'h00;
            dq_sync_q <= 8'h00;
        end else begin
            dq_meta_q <= byte_lines_i;
            dq_sync_q <= dq_meta_q;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= PH_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            rdata_q <= 8'h00;
            pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr_lines: 15'h0000};
            byte_lines_o_q <= 8'h00;
            byte_lines_oe_q <= 1'b0;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (start) begin
                        // Address settles with chip select still high
                        pins_q.addr_lines <= addr;
                        wr_q <= is_write;
                        byte_lines_o_q <= wdata;
                        phase_q <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    // Write strobe falls with select, so outputs never turn on
                    pins_q.ce_n <= 1'b0;
                    pins_q.we_n <= !wr_q;
                    pins_q.oe_n <= wr_q;
                    byte_lines_oe_q <= wr_q;
                    cnt_q <= wr_q ? 4'(nvc_pkg::WP_CYC - 1) : 4'(nvc_pkg::RD_CYC - 1);
                    phase_q <= PH_STROBE;
                end
                PH_STROBE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        if (!wr_q) begin
                            rdata_q <= dq_sync_q;
                        end
                        // Select rises and ends a write; data held one more phase
                        pins_q.ce_n <= 1'b1;
                        pins_q.we_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        cnt_q <= 4'(nvc_pkg::HZ_CYC - 1);
                        phase_q <= PH_RECOV;
                    end
                end
                PH_RECOV: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        byte_lines_oe_q <= 1'b0;
                        phase_q <= PH_IDLE;
                    end
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    sequence s_wr_strobe;
        !pins_q.ce_n && !pins_q.we_n;
    endsequence

    a_oe_high_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_wr_strobe |-> pins_q.oe_n && byte_lines_oe_q)
        else $error("output gating low or data not driven during write");

    a_addr_stable_sel: assert property (@(posedge mclk) disable iff (!reset_n)
        !pins_q.ce_n && !$past(pins_q.ce_n) |-> $stable(pins_q.addr_lines))
        else $error("address moved while selected");

    a_write_pulse_len: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(pins_q.we_n) |-> !pins_q.we_n [*5] ##1 pins_q.we_n && pins_q.ce_n)
        else $error("write pulse length wrong");

    a_read_gating: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(pins_q.ce_n) && pins_q.we_n |-> !pins_q.oe_n [*8] ##1 !pins_q.oe_n ##1 pins_q.oe_n)
        else $error("read strobe shape wrong");

endmodule

`default_nettype wire

// [nvc_host.sv]
// Host controller for a byte-wide static RAM shadowed by nonvolatile cells:
// plain reads and writes, six-read software save and load, hardware save
// over the shared open-drain busy pin, and the power-up load wait.
// Assumes the memory pins are wired directly and the busy pin has a pull-up.
`timescale 1ns/10ps
`default_nettype none

module nvc_host #(
    parameter int SAVE_CYC = nvc_pkg::SAVE_CYC,
    parameter int PWRUP_CYC = nvc_pkg::PWRUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nvc_pkg::nvc_cmd_t cmd,
    output logic rsp_valid_q,
    output logic [nvc_pkg::DATA_W-1:0] rsp_data,
    output logic busy,
    // Memory control and address pins
    output nvc_pkg::nvc_pins_t pins,
    // Data pins
    output logic [nvc_pkg::DATA_W-1:0] byte_lines_o,
    output logic byte_lines_oe,
    input wire logic [nvc_pkg::DATA_W-1:0] byte_lines_i,
    // Open-drain save request and busy pin
    input wire logic hw_store_busy_n_i,
    output logic hw_store_busy_n_o,
    output logic hw_store_busy_n_oe
);

    typedef enum {ST_PWRUP, ST_IDLE, ST_ACCESS, ST_SEQ, ST_NVWAIT,
                  ST_HSB_DRIVE, ST_HSB_WAIT} nvc_state_t;

    localparam int W = nvc_pkg::WAIT_W;

    nvc_state_t state_q;
    logic [W-1:0] wait_q;
    logic [2:0] seq_idx_q;
    logic load_q;
    logic acc_wr_q;
    logic hsb_meta_q;
    logic hsb_sync_q;
    logic hsb_oe_q;

    logic cyc_busy;
    logic cyc_done;
    logic [nvc_pkg::DATA_W-1:0] cyc_rdata;

    // Address of one step of the mode sequence; the top bit is driven low
    function automatic logic [nvc_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                          input logic load);
        logic [13:0] low;
        low = nvc_pkg::SEQ_SAVE_LAST;
        if (idx < 3'(nvc_pkg::SEQ_LEN - 1)) begin
            low = nvc_pkg::SEQ_PREFIX[idx];
        end else if (load) begin
            low = nvc_pkg::SEQ_LOAD_LAST;
        end
        return {1'b0, low};
    endfunction

    wire idle = (state_q == ST_IDLE);
    wire wait_zero = (wait_q == '0);
    wire cmd_fire = cmd_valid && cmd_ready;
    wire cmd_is_rw = (cmd.op == nvc_pkg::NVC_OP_READ) || (cmd.op == nvc_pkg::NVC_OP_WRITE);
    wire seq_last = (seq_idx_q == 3'(nvc_pkg::SEQ_LEN - 1));

    // Nothing is started while any save holds the busy pin low
    assign cmd_ready = idle && hsb_sync_q;
    assign busy = !idle;

    // Each sequence read is its own select cycle, strobe held high
    wire cyc_start = (idle && cmd_fire && cmd_is_rw) ||
                     ((state_q == ST_SEQ) && !cyc_busy);
    wire cyc_write = idle && (cmd.op == nvc_pkg::NVC_OP_WRITE);
    wire [nvc_pkg::ADDR_W-1:0] cyc_addr = (state_q == ST_SEQ) ?
                                          seq_addr(seq_idx_q, load_q) : cmd.addr;

    assign rsp_data = cyc_rdata;
    assign hw_store_busy_n_o = 1'b0;
    assign hw_store_busy_n_oe = hsb_oe_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hsb_meta_q <= 1'b1;
            hsb_sync_q <= 1'b1;
        end else begin
            hsb_meta_q <= hw_store_busy_n_i;
            hsb_sync_q <= hsb_meta_q;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_PWRUP;
            wait_q <= W'(PWRUP_CYC - 1);
            seq_idx_q <= 3'h0;
            load_q <= 1'b0;
            acc_wr_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            hsb_oe_q <= 1'b0;
        end else begin
            rsp_valid_q <= (state_q == ST_ACCESS) && cyc_done && !acc_wr_q;
            if (!wait_zero) begin
                wait_q <= wait_q - W'(1);
            end
            case (state_q)
                ST_PWRUP: begin
                    // Select and strobe stay high until the power-up load is over
                    if (wait_zero) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (cmd_fire) begin
                        acc_wr_q <= (cmd.op == nvc_pkg::NVC_OP_WRITE);
                        load_q <= (cmd.op == nvc_pkg::NVC_OP_SW_LOAD);
                        seq_idx_q <= 3'h0;
                        if (cmd_is_rw) begin
                            state_q <= ST_ACCESS;
                        end else if (cmd.op == nvc_pkg::NVC_OP_HW_SAVE) begin
                            hsb_oe_q <= 1'b1;
                            wait_q <= W'(nvc_pkg::HSB_HOLD_CYC - 1);
                            state_q <= ST_HSB_DRIVE;
                        end else begin
                            state_q <= ST_SEQ;
                        end
                    end
                end
                ST_ACCESS: begin
                    if (cyc_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SEQ: begin
                    // No other access is let in between the six reads
                    if (cyc_done) begin
                        seq_idx_q <= seq_idx_q + 3'h1;
                        if (seq_last) begin
                            wait_q <= load_q ? W'(nvc_pkg::LOAD_CYC - 1) : W'(SAVE_CYC - 1);
                            state_q <= ST_NVWAIT;
                        end
                    end
                end
                ST_NVWAIT: begin
                    if (wait_zero) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HSB_DRIVE: begin
                    if (wait_zero) begin
                        hsb_oe_q <= 1'b0;
                        wait_q <= W'(nvc_pkg::HSB_SETTLE_CYC - 1);
                        state_q <= ST_HSB_WAIT;
                    end
                end
                ST_HSB_WAIT: begin
                    // Device may skip an unneeded save, so the pin may already be high
                    if (wait_zero && hsb_sync_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    nvc_cycle u_cycle (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cmd.wdata),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata_q(cyc_rdata),
        .pins_q(pins),
        .byte_lines_o_q(byte_lines_o),
        .byte_lines_oe_q(byte_lines_oe),
        .byte_lines_i(byte_lines_i)
    );

    sequence s_seq_done;
        (state_q == ST_SEQ) && cyc_done && seq_last;
    endsequence

    sequence s_nv_quiet;
        pins.ce_n && !cmd_ready [*8];
    endsequence

    a_seq_no_write: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_SEQ) |-> pins.we_n && !byte_lines_oe)
        else $error("write strobe low during mode sequence");

    a_seq_ce_toggle: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_SEQ) && cyc_done |-> pins.ce_n ##1 pins.ce_n)
        else $error("select not released between sequence reads");

    a_seq_quiet_after: assert property (@(posedge mclk) disable iff (!reset_n)
        s_seq_done |=> s_nv_quiet)
        else $error("access started during nonvolatile cycle");

    a_seq_top_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_SEQ) && !pins.ce_n |-> !pins.addr_lines[14])
        else $error("sequence drove top address bit");

    a_seq_last_addr: assert property (@(posedge mclk) disable iff (!reset_n)
        s_seq_done |-> pins.addr_lines[13:0] ==
            (load_q ? nvc_pkg::SEQ_LOAD_LAST : nvc_pkg::SEQ_SAVE_LAST))
        else $error("wrong sixth sequence address");

    a_pwrup_idle_pins: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_PWRUP) |-> pins.ce_n && pins.we_n && !cmd_ready)
        else $error("pins active during power-up load");

    a_busy_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
        !hsb_sync_q && idle |=> idle && pins.ce_n)
        else $error("command taken while busy pin low");

    a_rsp_after_read: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_ACCESS) && cyc_done && !acc_wr_q |=> rsp_valid_q ##1 !rsp_valid_q)
        else $error("read answer missing or too long");

endmodule

`default_nettype wire

// [nvc_sram_model.sv]
// Behavioural model of the shadowed static RAM seen from its pins.
// Assumes the bench resolves the shared data lines and the pulled-up busy pin.
`timescale 1ns/10ps
`default_nettype none

module nvc_sram_model #(
    parameter int SAVE_NS = 300,
    parameter int LOAD_NS = 1000,
    parameter int PWRUP_NS = 100,
    parameter int DRAIN_NS = 1000
) (
    // Control and address
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [14:0] addr,
    // Data and busy pin
    input wire logic [7:0] dq,
    input wire logic hw_store_busy_n,
    output logic [7:0] dq_o,
    output logic dq_oe,
    output logic hsb_pull
);
    logic [7:0] mem [32768];
    logic [7:0] nv [32768];
    logic [13:0] seq [5] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
    logic nv_busy = 1'b1;
    logic dirty = 1'b0;
    logic wr_on = 1'b0;
    int pos = 0;

    // Data follows the address with no control edge needed
    assign dq_oe = !ce_n && !oe_n && we_n && hw_store_busy_n && !nv_busy;
    assign dq_o = mem[addr];

    task automatic nv_load(input int ns);
        nv_busy = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
        #(ns);
        foreach (mem[i]) mem[i] = nv[i];
        dirty = 1'b0;
        nv_busy = 1'b0;
    endtask

    // Busy pin pulled low through the drain window, which gates off accesses, then the array locks
    task automatic nv_save(input int drain_ns);
        hsb_pull = 1'b1;
        #(drain_ns);
        nv_busy = 1'b1;
        foreach (nv[i]) nv[i] = 8'hFF;
        #(SAVE_NS);
        foreach (nv[i]) nv[i] = mem[i];
        dirty = 1'b0;
        nv_busy = 1'b0;
        hsb_pull = 1'b0;
    endtask

    initial begin
        hsb_pull = 1'b0;
        foreach (nv[i]) nv[i] = 8'(i) ^ 8'h5A;
        nv_load(PWRUP_NS);
    end

    // Gating input takes no part in the match
    always @(negedge ce_n) begin
        if (!nv_busy && hw_store_busy_n) begin
            if (!we_n) pos = 0;
            else if (pos == 5 && addr[13:0] == 14'h0FC0) begin
                pos = 0;
                nv_save(0);
            end else if (pos == 5 && addr[13:0] == 14'h0C63) begin
                pos = 0;
                nv_load(LOAD_NS);
            end else if (pos < 5 && addr[13:0] == seq[pos]) pos++;
            else pos = (addr[13:0] == seq[0]) ? 1 : 0;
        end
    end

    // Byte taken when select or strobe ends the write, whichever first
    always @(ce_n or we_n) begin
        if (!ce_n && !we_n && hw_store_busy_n && !nv_busy) wr_on = 1'b1;
        else if (wr_on) begin
            mem[addr] = dq;
            dirty = 1'b1;
            wr_on = 1'b0;
            pos = 0;
        end
    end

    always @(negedge hw_store_busy_n) begin
        if (!hsb_pull && dirty) nv_save(DRAIN_NS);
    end
endmodule

`default_nettype wire

// [nvc_host_bench.sv]
// Self-checking bench for the shadowed static RAM host controller.
// Assumes the behavioural memory model of nvc_sram_model.sv.
`timescale 1ns/10ps
`default_nettype none

module nvc_host_bench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    nvc_pkg::nvc_cmd_t cmd = '0;
    nvc_pkg::nvc_pins_t pins;
    logic cmd_ready, rsp_valid_q, busy, oe_q, dq_oe, hsb_o, hsb_oe, hsb_pull, hsb_bus;
    logic [7:0] rsp_data, dq_host, dq_dev, dq_bus, rd;
    logic [7:0] dq_last = 8'h00;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int low_cnt = 0;
    int ce_falls = 0;
    int we_low = 0;

    // Released data lines show the inverse of the last driven value
    assign dq_bus = oe_q ? dq_host : (dq_oe ? dq_dev : ~dq_last);
    assign hsb_bus = !((hsb_oe && !hsb_o) || hsb_pull);
    always @(dq_bus) if (oe_q || dq_oe) dq_last = dq_bus;

    nvc_host #(.SAVE_CYC(50), .PWRUP_CYC(20)) i_nvc_host (
        .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid_q(rsp_valid_q), .rsp_data(rsp_data), .busy(busy),
        .pins(pins), .byte_lines_o(dq_host), .byte_lines_oe(oe_q),
        .byte_lines_i(dq_bus), .hw_store_busy_n_i(hsb_bus),
        .hw_store_busy_n_o(hsb_o), .hw_store_busy_n_oe(hsb_oe));

    nvc_sram_model i_nvc_sram_model (
        .ce_n(pins.ce_n), .we_n(pins.we_n), .oe_n(pins.oe_n), .addr(pins.addr_lines),
        .dq(dq_bus), .hw_store_busy_n(hsb_bus), .dq_o(dq_dev), .dq_oe(dq_oe), .hsb_pull(hsb_pull));

    initial begin
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (!hsb_bus) low_cnt <= low_cnt + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    always @(negedge pins.ce_n) begin
        ce_falls++;
        if (!pins.we_n) we_low++;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Request held from a falling edge until a rising edge sees ready
    task automatic do_cmd(input nvc_pkg::nvc_op_t op, input logic [14:0] a,
                          input logic [7:0] d);
        int n;
        rd = 'x;
        @(negedge mclk);
        cmd = '{op, a, d};
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        chk("cmd_ready", cmd_ready, 1'b1);
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge mclk);
            if (rsp_valid_q === 1'b1) rd = rsp_data;
            n++;
        end
        chk("busy", busy, 1'b0);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        do_cmd(nvc_pkg::NVC_OP_WRITE, a, d);
    endtask

    task automatic rdchk(input string name, input logic [14:0] a, input logic [7:0] exp);
        do_cmd(nvc_pkg::NVC_OP_READ, a, 8'h00);
        chk(name, rd, exp);
    endtask

    task automatic t_powerup();
        chk("busy_pwrup", busy, 1'b1);
        chk("ce_n_pwrup", pins.ce_n, 1'b1);
        chk("we_n_pwrup", pins.we_n, 1'b1);
        rdchk("pwrup_data", 15'h0042, 8'h42 ^ 8'h5A);
    endtask

    task automatic t_rw();
        wr(15'h7FFF, 8'h3C);
        wr(15'h3FFF, 8'hC3);
        rdchk("rd_top", 15'h7FFF, 8'h3C);
        rdchk("rd_alias", 15'h3FFF, 8'hC3);
    endtask

    task automatic t_sw();
        wr(15'h0123, 8'h77);
        ce_falls = 0;
        we_low = 0;
        low_cnt = 0;
        do_cmd(nvc_pkg::NVC_OP_SW_SAVE, 15'h0000, 8'h00);
        chk("seq_reads", ce_falls, 6);
        chk("seq_we_low", we_low, 0);
        chk("save_pin_low", low_cnt > 0, 1'b1);
        wr(15'h0123, 8'h11);
        do_cmd(nvc_pkg::NVC_OP_SW_LOAD, 15'h0000, 8'h00);
        rdchk("load_saved", 15'h0123, 8'h77);
        rdchk("load_other", 15'h0042, 8'h42 ^ 8'h5A);
    endtask

    task automatic t_clean();
        low_cnt = 0;
        do_cmd(nvc_pkg::NVC_OP_SW_SAVE, 15'h0000, 8'h00);
        chk("sw_save_clean", low_cnt > 0, 1'b1);
        low_cnt = 0;
        do_cmd(nvc_pkg::NVC_OP_HW_SAVE, 15'h0000, 8'h00);
        chk("hw_skip", low_cnt <= nvc_pkg::HSB_HOLD_CYC + 2, 1'b1);
        wr(15'h0123, 8'h99);
        low_cnt = 0;
        do_cmd(nvc_pkg::NVC_OP_HW_SAVE, 15'h0000, 8'h00);
        chk("hw_save", low_cnt > nvc_pkg::HSB_HOLD_CYC + 100, 1'b1);
        wr(15'h0123, 8'h22);
        do_cmd(nvc_pkg::NVC_OP_SW_LOAD, 15'h0000, 8'h00);
        rdchk("hw_saved", 15'h0123, 8'h99);
    endtask

    task automatic t_abort();
        logic [14:0] seq [6] = '{15'h0E38, 15'h31C7, 15'h03E0, 15'h3C1F, 15'h303F,
                                 15'h0FC0};
        low_cnt = 0;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) wr(15'h0500, 8'h5A);
            do_cmd(nvc_pkg::NVC_OP_READ, seq[i], 8'h00);
        end
        chk("abort_no_save", low_cnt, 0);
        for (int i = 0; i < 6; i++) do_cmd(nvc_pkg::NVC_OP_READ, seq[i] | 15'h4000, 8'h00);
        repeat (10) @(negedge mclk);
        chk("restart_save", low_cnt > 0, 1'b1);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        t_powerup();
        t_rw();
        t_sw();
        t_clean();
        t_abort();
        give_verdict();
    end
endmodule

`default_nettype wire
